// ---- mic_pkg.sv ----
// package for the microcontroller interrupt controller
package mic_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_INT_CONTROL = 8'h0B;
  localparam logic [7:0] OFS_INT_CONTROL_HI = 8'h8B;
  localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_PERIPH_ENABLES = 8'h8C;
  localparam logic [7:0] OFS_PIN_CHANGE_MASK = 8'h96;
  localparam logic [7:0] OFS_OPTION = 8'h81;
  localparam logic [7:0] OFS_POWER_STATUS = 8'h8E;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hF1;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int TIMER0_EN_BIT = 5;
  localparam int EXT_PIN_EN_BIT = 4;
  localparam int PORT_CHG_EN_BIT = 3;
  localparam int TIMER0_FLAG_BIT = 2;
  localparam int EXT_PIN_FLAG_BIT = 1;
  localparam int PORT_CHG_FLAG_BIT = 0;
  localparam int EDGE_SEL_BIT = 6;
  localparam int PERIPH_UNUSED_BIT = 4;

  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [7:0] INT_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [5:0] PIN_MASK_RST = 6'h00;
  localparam logic [3:0] PWR_POR_VAL = 4'h4;
  localparam logic [3:0] PWR_BOR_VAL = 4'h6;
  localparam logic [12:0] PC_RESET_VEC = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
  localparam int IRQ_SYNC_CYCLES = 2;
  localparam int PINS = 6;

  // reset causes
  typedef enum logic [1:0] {
    MIC_RST_POR,
    MIC_RST_PIN,
    MIC_RST_WDT,
    MIC_RST_BOR
  } mic_rst_cause_e;

  // peripheral event pulses, one per flag position of the peripheral register
  typedef struct packed {
    logic eeprom_write;
    logic converter_done;
    logic capture_compare;
    logic unused;
    logic comparator;
    logic clock_fail;
    logic timer2_match;
    logic timer1_overflow;
  } mic_periph_ev_s;

  // commands from the core sequencer
  typedef struct packed {
    logic return_from_irq_instr;
    logic irq_ack;
    logic sleep_enter;
    logic port_read;
  } mic_core_cmd_s;

endpackage : mic_pkg

// ---- mic_irq_ctrl.sv ----
// interrupt controller: flags, enables, vectoring and wake from sleep
//
// Local design decision: the strobed register port.

module mic_irq_ctrl #(
  parameter int STACK_DEPTH = 8                   // hardware stack depth
) (
  input  wire logic                   clk,          // 125 MHz clock
  input  wire logic                   rst,          // async reset, high
  input  wire mic_pkg::mic_rst_cause_e rst_cause,   // cause of latest reset
  input  wire logic [7:0]             reg_addr,     // register address
  input  wire logic [7:0]             reg_wdata,    // write data
  input  wire logic                   reg_wr,       // write strobe
  input  wire logic                   reg_rd,       // read strobe
  input  wire logic                   ext_irq_pin,  // external pin, async
  input  wire logic [5:0]             port_pins,    // port pins, async
  input  wire logic                   timer0_wrap,  // timer0 count FFh to 00h
  input  wire mic_pkg::mic_periph_ev_s periph_ev,   // peripheral event pulses
  input  wire mic_pkg::mic_core_cmd_s core_cmd,     // core sequencer strobes
  input  wire logic [12:0]            ret_pc,       // return address to push
  output logic [7:0]                  reg_rdata,    // read data, next cycle
  output logic                        irq_vector,   // one-cycle vector request
  output logic [12:0]                 vector_pc,    // vector address
  output logic [12:0]                 stack_top,    // last pushed address
  output logic                        wake,         // wake pulse to core
  output logic                        asleep,       // core is asleep
  output logic                        irq_out,      // level interrupt output
  output logic [1:0]                  q_phase       // Q phase 0..3, registered one cycle late
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  interrupt_control_r;
  logic [7:0]  pflag_r;
  logic [7:0]  pen_r;
  logic [7:0]  option_r;
  logic [5:0]  pin_mask_r;
  logic [3:0]  pwr_r;
  logic [3:0]  ev_stat_r;
  logic [3:0]  ev_mask_r;
  logic [1:0]  q_r;
  logic [1:0]  pin_sync_r;
  logic        pin_prev_r;
  logic [5:0]  port_s1_r;
  logic [5:0]  port_s2_r;
  logic [5:0]  port_latch_r;
  logic [1:0]  lat_cnt_r;
  logic        pend_r;
  logic [12:0] stack_r [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] sp_r;
  logic        gie_block_r;

  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_SLEEP,
    MIC_WAKE_EXEC
  } mic_state_e;
  mic_state_e state_r;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] wr_keep(input logic [7:0] cur, input logic [7:0] set_v,
                                         input logic [7:0] wmask, input logic [7:0] wval);
    wr_keep = (cur & ~wmask) | (wval & wmask) | set_v;
  endfunction : wr_keep

  wire wr_ctl   = reg_wr && (reg_addr == mic_pkg::OFS_INT_CONTROL ||
                             reg_addr == mic_pkg::OFS_INT_CONTROL_HI);
  wire wr_pflag = reg_wr && reg_addr == mic_pkg::OFS_PERIPH_FLAGS;
  wire wr_pen   = reg_wr && reg_addr == mic_pkg::OFS_PERIPH_ENABLES;

  // ---------------------------------------------------------------
  // q phase divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= 2'h0;
    end else begin
      q_r <= q_r + 2'h1;
    end
  end
  wire cyc_end = (q_r == 2'h3);

  // ---------------------------------------------------------------
  // edge and change detection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // start high: rising select after reset sees no false edge
      pin_sync_r <= 2'h3;
      pin_prev_r <= 1'b1;
      port_s1_r  <= 6'h00;
      port_s2_r  <= 6'h00;
    end else begin
      pin_sync_r <= {pin_sync_r[0], ext_irq_pin};
      pin_prev_r <= pin_sync_r[1];
      port_s1_r  <= port_pins;
      port_s2_r  <= port_s1_r;
    end
  end

  wire edge_sel  = option_r[mic_pkg::EDGE_SEL_BIT];
  wire pin_edge  = edge_sel ? (pin_sync_r[1] & ~pin_prev_r)
                            : (~pin_sync_r[1] & pin_prev_r);
  // pin flag only armed in Q4 and Q1
  wire pin_win   = (q_r == 2'h3) || (q_r == 2'h0);
  logic pin_hold_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_hold_r <= 1'b0;
    end else begin
      pin_hold_r <= (pin_hold_r | pin_edge) & ~pin_win;
    end
  end
  wire pin_set = (pin_edge | pin_hold_r) & pin_win;

  // port latch follows the pins every cycle; a change during a port read in Q2 is missed
  wire port_rd_q2 = core_cmd.port_read && (q_r == 2'h1);
  wire port_chg   = |((port_s2_r ^ port_latch_r) & pin_mask_r) && !port_rd_q2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_latch_r <= 6'h00;
    end else begin
      port_latch_r <= port_s2_r;
    end
  end

  // ---------------------------------------------------------------
  // control register, flags set regardless of enables
  // ---------------------------------------------------------------
  logic [7:0] ctl_set;
  always_comb begin
    ctl_set = 8'h00;
    ctl_set[mic_pkg::TIMER0_FLAG_BIT]   = timer0_wrap;
    ctl_set[mic_pkg::EXT_PIN_FLAG_BIT]  = pin_set;
    ctl_set[mic_pkg::PORT_CHG_FLAG_BIT] = port_chg;
  end

  wire take = irq_vector;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_control_r <= mic_pkg::INT_CONTROL_RST;
    end else begin
      interrupt_control_r <= wr_keep(interrupt_control_r, ctl_set, wr_ctl ? 8'hFF : 8'h00, reg_wdata);
      if (take) begin
        interrupt_control_r[mic_pkg::GLOBAL_EN_BIT] <= 1'b0;
      end else if (core_cmd.return_from_irq_instr) begin
        interrupt_control_r[mic_pkg::GLOBAL_EN_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pflag_r <= mic_pkg::PERIPH_RST;
      pen_r   <= mic_pkg::PERIPH_RST;
    end else begin
      pflag_r <= wr_keep(pflag_r, periph_ev, wr_pflag ? 8'hFF : 8'h00, reg_wdata)
                 & ~(8'h01 << mic_pkg::PERIPH_UNUSED_BIT);
      if (wr_pen) begin
        pen_r <= reg_wdata & ~(8'h01 << mic_pkg::PERIPH_UNUSED_BIT);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      option_r   <= mic_pkg::OPTION_RST;
      pin_mask_r <= mic_pkg::PIN_MASK_RST;
    end else begin
      if (reg_wr && reg_addr == mic_pkg::OFS_OPTION) begin
        option_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == mic_pkg::OFS_PIN_CHANGE_MASK) begin
        pin_mask_r <= reg_wdata[5:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // request tree
  // ---------------------------------------------------------------
  wire periph_req = interrupt_control_r[mic_pkg::PERIPH_EN_BIT] & |(pflag_r & pen_r);
  wire src_req = (interrupt_control_r[mic_pkg::TIMER0_EN_BIT]  & interrupt_control_r[mic_pkg::TIMER0_FLAG_BIT]) |
                 (interrupt_control_r[mic_pkg::EXT_PIN_EN_BIT] & interrupt_control_r[mic_pkg::EXT_PIN_FLAG_BIT]) |
                 (interrupt_control_r[mic_pkg::PORT_CHG_EN_BIT] & interrupt_control_r[mic_pkg::PORT_CHG_FLAG_BIT]) |
                 periph_req;
  wire global_irq_enable = interrupt_control_r[mic_pkg::GLOBAL_EN_BIT];

  // a write clearing the global enable blocks requests due next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gie_block_r <= 1'b0;
    end else begin
      gie_block_r <= wr_ctl && !reg_wdata[mic_pkg::GLOBAL_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // sequencing: latency counter, sleep and wake
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= MIC_RUN;
      pend_r      <= 1'b0;
      lat_cnt_r   <= 2'h0;
      irq_vector  <= 1'b0;
      wake        <= 1'b0;
    end else begin
      irq_vector <= 1'b0;
      wake       <= 1'b0;
      case (state_r)
        MIC_RUN: begin
          if (core_cmd.sleep_enter) begin
            state_r <= MIC_SLEEP;
            pend_r  <= 1'b0;
          end else if (src_req && global_irq_enable && !gie_block_r) begin
            // request seen, vector after fixed instruction cycles
            if (!pend_r) begin
              pend_r    <= 1'b1;
              lat_cnt_r <= 2'h0;
            end else if (cyc_end) begin
              if (lat_cnt_r == 2'h2) begin
                irq_vector <= 1'b1;
                pend_r     <= 1'b0;
              end else begin
                lat_cnt_r <= lat_cnt_r + 2'h1;
              end
            end
          end else begin
            pend_r <= 1'b0;
          end
        end
        MIC_SLEEP: begin
          if (src_req) begin
            wake    <= 1'b1;
            state_r <= MIC_WAKE_EXEC;
          end
        end
        MIC_WAKE_EXEC: begin
          // core runs PC+1 until the end of the current instruction cycle first
          if (cyc_end) begin
            state_r <= MIC_RUN;
            if (global_irq_enable) begin
              irq_vector <= 1'b1;
            end
          end
        end
        default: state_r <= MIC_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // return stack: only the return PC is saved
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_r      <= '0;
      stack_top <= mic_pkg::PC_RESET_VEC;
      vector_pc <= mic_pkg::PC_RESET_VEC;
    end else begin
      if (take) begin
        stack_r[sp_r] <= ret_pc;
        stack_top     <= ret_pc;
        sp_r          <= sp_r + 1'b1;
        vector_pc     <= mic_pkg::PC_IRQ_VEC;
      end else if (core_cmd.return_from_irq_instr) begin
        sp_r      <= sp_r - 1'b1;
        stack_top <= stack_r[sp_r - 1'b1];
      end
    end
  end

  // ---------------------------------------------------------------
  // power status: caught after reset release from the cause input
  // ---------------------------------------------------------------
  logic pwr_done_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_done_r <= 1'b0;
    end else begin
      pwr_done_r <= 1'b1;
    end
  end

  // no reset here: pin and watchdog resets keep the low bits
  always_ff @(posedge clk) begin
    if (!rst && !pwr_done_r) begin
      case (rst_cause)
        mic_pkg::MIC_RST_POR: pwr_r <= mic_pkg::PWR_POR_VAL;
        mic_pkg::MIC_RST_BOR: pwr_r <= mic_pkg::PWR_BOR_VAL;
        default:              pwr_r <= {1'b0, pwr_r[2:0]};
      endcase
    end else if (!rst && reg_wr && reg_addr == mic_pkg::OFS_POWER_STATUS) begin
      pwr_r <= reg_wdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // block interrupt: sticky events, mask, write-one-to-clear
  // ---------------------------------------------------------------
  wire [3:0] ev_now = {wake, irq_vector, |periph_ev, |ctl_set};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_stat_r <= 4'h0;
      ev_mask_r <= 4'h0;
      irq_out   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == mic_pkg::OFS_IRQ_STATUS) begin
        ev_stat_r <= (ev_stat_r & ~reg_wdata[3:0]) | ev_now;
      end else begin
        ev_stat_r <= ev_stat_r | ev_now;
      end
      if (reg_wr && reg_addr == mic_pkg::OFS_IRQ_MASK) begin
        ev_mask_r <= reg_wdata[3:0];
      end
      irq_out <= |(ev_stat_r & ev_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // read port and status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      asleep    <= 1'b0;
      q_phase   <= 2'h0;
    end else begin
      asleep  <= (state_r == MIC_SLEEP);
      q_phase <= q_r;
      if (reg_rd) begin
        case (reg_addr)
          mic_pkg::OFS_INT_CONTROL,
          mic_pkg::OFS_INT_CONTROL_HI:  reg_rdata <= interrupt_control_r;
          mic_pkg::OFS_PERIPH_FLAGS:    reg_rdata <= pflag_r;
          mic_pkg::OFS_PERIPH_ENABLES:  reg_rdata <= pen_r;
          mic_pkg::OFS_OPTION:          reg_rdata <= option_r;
          mic_pkg::OFS_PIN_CHANGE_MASK: reg_rdata <= {2'h0, pin_mask_r};
          mic_pkg::OFS_POWER_STATUS:    reg_rdata <= {4'h0, pwr_r};
          mic_pkg::OFS_IRQ_STATUS:      reg_rdata <= {4'h0, ev_stat_r};
          mic_pkg::OFS_IRQ_MASK:        reg_rdata <= {4'h0, ev_mask_r};
          default:                      reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule : mic_irq_ctrl

// ---- mic_irq_ctrl_checker.sv ----
// port assertions for the interrupt controller
module mic_irq_ctrl_checker #(
  parameter int STACK_DEPTH = 8                  // stack depth
) (
  input wire logic                    clk,        // clock
  input wire logic                    rst,        // async reset
  input wire mic_pkg::mic_rst_cause_e rst_cause,  // reset cause
  input wire logic [7:0]              reg_addr,   // address
  input wire logic [7:0]              reg_wdata,  // write data
  input wire logic                    reg_wr,     // write strobe
  input wire logic                    reg_rd,     // read strobe
  input wire logic                    ext_irq_pin, // pin
  input wire logic [5:0]              port_pins,  // port pins
  input wire logic                    timer0_wrap, // timer0 wrap
  input wire mic_pkg::mic_periph_ev_s periph_ev,  // events
  input wire mic_pkg::mic_core_cmd_s  core_cmd,   // core strobes
  input wire logic [12:0]             ret_pc,     // return address
  input wire logic [7:0]              reg_rdata,  // read data
  input wire logic                    irq_vector, // vector pulse
  input wire logic [12:0]             vector_pc,  // vector address
  input wire logic [12:0]             stack_top,  // stack top
  input wire logic                    wake,       // wake pulse
  input wire logic                    asleep,     // asleep
  input wire logic                    irq_out,    // interrupt level
  input wire logic [1:0]              q_phase     // q phase
);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic       blocked_r;
  logic [1:0] up_cnt_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // global enable known to be clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blocked_r <= 1'b1;
    end else if (irq_vector) begin
      blocked_r <= 1'b1;
    end else if (core_cmd.return_from_irq_instr) begin
      blocked_r <= 1'b0;
    end else if (reg_wr && (reg_addr == mic_pkg::OFS_INT_CONTROL ||
                            reg_addr == mic_pkg::OFS_INT_CONTROL_HI)) begin
      blocked_r <= !reg_wdata[mic_pkg::GLOBAL_EN_BIT];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cnt_r <= 2'h0;
    end else if (up_cnt_r != 2'h3) begin
      up_cnt_r <= up_cnt_r + 2'h1;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h55 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_vector_addr: assert property (irq_vector |-> ##[0:1] vector_pc == mic_pkg::PC_IRQ_VEC)
    else $error("vector address wrong");
  a_vector_push: assert property (irq_vector |=> stack_top == $past(ret_pc))
    else $error("return address not pushed");
  a_vector_pulse: assert property (irq_vector |=> !irq_vector)
    else $error("vector longer than one cycle");
  a_gie_blocks: assert property (blocked_r && $past(blocked_r) |-> !irq_vector)
    else $error("vector while global enable clear");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_wake_exit: assert property (wake |-> ##[0:1] !asleep)
    else $error("still asleep after wake");
  a_sleep_entry: assert property (core_cmd.sleep_enter |-> ##[1:2] asleep)
    else $error("sleep not entered");
  a_phase_step: assert property (up_cnt_r == 2'h3 && !asleep && !$past(asleep)
    |-> q_phase == $past(q_phase) + 2'h1)
    else $error("q phase did not advance");
endmodule : mic_irq_ctrl_checker

bind mic_irq_ctrl mic_irq_ctrl_checker #(.STACK_DEPTH(STACK_DEPTH)) chk_inst (.clk(clk),
  .rst(rst), .rst_cause(rst_cause), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .ext_irq_pin(ext_irq_pin), .port_pins(port_pins),
  .timer0_wrap(timer0_wrap), .periph_ev(periph_ev), .core_cmd(core_cmd), .ret_pc(ret_pc),
  .reg_rdata(reg_rdata), .irq_vector(irq_vector), .vector_pc(vector_pc),
  .stack_top(stack_top), .wake(wake), .asleep(asleep), .irq_out(irq_out), .q_phase(q_phase));

// ---- mic_core_model.sv ----
// behavioural core sequencer facing the interrupt controller
module mic_core_model (
  input  wire logic              clk,           // clock
  input  wire logic              rst,           // async reset
  input  wire logic              irq_vector,    // vector request
  input  wire logic              wake,          // wake pulse
  input  wire logic              asleep,        // core asleep
  input  wire logic              return_from_irq_instr_req,    // return from interrupt
  input  wire logic              sleep_req,     // sleep instruction
  input  wire logic              port_read_req, // port read
  output mic_pkg::mic_core_cmd_s core_cmd,      // strobes out
  output logic [12:0]            ret_pc         // program counter
);
  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------
  logic [12:0] pc_r;
  assign core_cmd = {return_from_irq_instr_req, 1'b0, sleep_req, port_read_req};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r <= mic_pkg::PC_RESET_VEC;
    end else if (irq_vector) begin
      pc_r <= mic_pkg::PC_IRQ_VEC;
    end else if (wake || !asleep) begin
      pc_r <= pc_r + 13'h0001;
    end
  end
  assign ret_pc = pc_r;
endmodule : mic_core_model

// ---- tb.sv ----
// self-checking testbench for the interrupt controller
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); mismatches++; end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam logic [7:0] CTL = mic_pkg::OFS_INT_CONTROL, PFL = mic_pkg::OFS_PERIPH_FLAGS,
    PEN = mic_pkg::OFS_PERIPH_ENABLES, OPT = mic_pkg::OFS_OPTION,
    PWR = mic_pkg::OFS_POWER_STATUS, IST = mic_pkg::OFS_IRQ_STATUS, IMK = mic_pkg::OFS_IRQ_MASK;
  logic                    clk, rst, reg_wr, reg_rd, ext_irq_pin, timer0_wrap;
  logic                    irq_vector, wake, asleep, irq_out, return_from_irq_instr_req, sleep_req, port_read_req;
  logic [7:0]              reg_addr, reg_wdata, reg_rdata;
  logic [5:0]              port_pins;
  logic [12:0]             ret_pc, vector_pc, stack_top;
  logic [1:0]              q_phase;
  mic_pkg::mic_rst_cause_e rst_cause;
  mic_pkg::mic_periph_ev_s periph_ev;
  mic_pkg::mic_core_cmd_s  core_cmd;
  int                      mismatches = 0, tests_run = 0, n;
  mic_irq_ctrl #(.STACK_DEPTH(8)) mic_irq_ctrl_inst (.clk(clk), .rst(rst), .rst_cause(rst_cause),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .ext_irq_pin(ext_irq_pin), .port_pins(port_pins), .timer0_wrap(timer0_wrap),
    .periph_ev(periph_ev), .core_cmd(core_cmd), .ret_pc(ret_pc), .reg_rdata(reg_rdata),
    .irq_vector(irq_vector), .vector_pc(vector_pc), .stack_top(stack_top), .wake(wake),
    .asleep(asleep), .irq_out(irq_out), .q_phase(q_phase));
  mic_core_model mic_core_model_inst (.clk(clk), .rst(rst), .irq_vector(irq_vector),
    .wake(wake), .asleep(asleep), .return_from_irq_instr_req(return_from_irq_instr_req), .sleep_req(sleep_req),
    .port_read_req(port_read_req), .core_cmd(core_cmd), .ret_pc(ret_pc));
  always #4 clk = ~clk;
  // ---------------------------------------------------------------
  // bus and helper tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
    @(posedge clk);
  endtask : rd_chk
  task automatic pulse_ev(input logic [7:0] v);
    @(posedge clk);
    periph_ev <= mic_pkg::mic_periph_ev_s'(v);
    @(posedge clk);
    periph_ev <= '0;
  endtask : pulse_ev
  task automatic wait_vec(input int lim);
    n = 0;
    while (irq_vector !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_vec
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset(input logic [3:0] pwr);
    rd_chk(CTL, 8'h00);
    rd_chk(PFL, 8'h00);
    rd_chk(OPT, mic_pkg::OPTION_RST);
    rd_chk(PWR, {4'h0, pwr});
    rd_chk(8'h55, 8'h00);
    `CHK(vector_pc, mic_pkg::PC_RESET_VEC)
  endtask : t_reset
  task automatic t_periph;
    logic [7:0] exp = 8'h00;
    wr(PEN, 8'hFF);
    rd_chk(PEN, 8'hEF);
    wr(PEN, 8'h00);
    for (int i = 0; i < 8; i++) begin
      pulse_ev(8'h01 << i);
      exp = exp | ((8'h01 << i) & 8'hEF);
      rd_chk(PFL, exp);
    end
    wr(PFL, 8'h00);
    wr(PEN, 8'h01);
    pulse_ev(8'h01);
    wr(CTL, 8'h80);
    wait_vec(30);
    `CHK(n, 30)
    wr(CTL, 8'hC0);
    wait_vec(30);
    `CHK(n < 30, 1'b1)
    wr(PFL, 8'h00);
    wr(PEN, 8'h00);
  endtask : t_periph
  task automatic t_ext_pin;
    wr(OPT, 8'hBF);
    wr(CTL, 8'h90);
    @(posedge clk);
    ext_irq_pin <= 1'b0;
    wait_vec(30);
    `CHK(n >= 12 && n <= 24, 1'b1)
    @(posedge clk);
    #1;
    `CHK(vector_pc, mic_pkg::PC_IRQ_VEC)
    rd_chk(CTL, 8'h12);
    wr(CTL, 8'h10);
    @(posedge clk);
    return_from_irq_instr_req <= 1'b1;
    @(posedge clk);
    return_from_irq_instr_req <= 1'b0;
    rd_chk(CTL, 8'h90);
    ext_irq_pin <= 1'b1;
    wait_vec(30);
    `CHK(n, 30)
    rd_chk(CTL, 8'h90);
    wr(CTL, 8'h00);
  endtask : t_ext_pin
  task automatic t_timer0;
    wr(CTL, 8'h20);
    @(posedge clk);
    timer0_wrap <= 1'b1;
    @(posedge clk);
    timer0_wrap <= 1'b0;
    wait_vec(30);
    `CHK(n, 30)
    rd_chk(CTL, 8'h24);
    wr(CTL, 8'hA4);
    wait_vec(30);
    `CHK(n < 30, 1'b1)
    rd_chk(CTL, 8'h24);
    wr(CTL, 8'h00);
  endtask : t_timer0
  task automatic t_port;
    wr(mic_pkg::OFS_PIN_CHANGE_MASK, 8'h01);
    port_pins <= 6'h02;
    repeat (8) @(posedge clk);
    rd_chk(CTL, 8'h00);
    port_pins <= 6'h03;
    repeat (8) @(posedge clk);
    rd_chk(CTL, 8'h01);
    wr(CTL, 8'h00);
  endtask : t_port
  task automatic t_irq_out;
    wr(IST, 8'hFF);
    wr(IMK, 8'h00);
    pulse_ev(8'h02);
    repeat (3) @(posedge clk);
    `CHK(irq_out, 1'b0)
    rd_chk(IST, 8'h02);
    wr(IMK, 8'h02);
    repeat (2) @(posedge clk);
    `CHK(irq_out, 1'b1)
    wr(IST, 8'h02);
    repeat (2) @(posedge clk);
    `CHK(irq_out, 1'b0)
    wr(PFL, 8'h00);
  endtask : t_irq_out
  task automatic t_sleep;
    wr(CTL, 8'h10);
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(asleep, 1'b1)
    ext_irq_pin <= 1'b0;
    n = 0;
    while (asleep === 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    `CHK(asleep, 1'b0)
    wait_vec(30);
    `CHK(n, 30)
    ext_irq_pin <= 1'b1;
    wr(CTL, 8'h90);
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
    ext_irq_pin <= 1'b0;
    wait_vec(60);
    `CHK(n < 60, 1'b1)
    ext_irq_pin <= 1'b1;
    wr(CTL, 8'h00);
  endtask : t_sleep
  task automatic print_verdict;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    {clk, reg_wr, reg_rd, timer0_wrap, return_from_irq_instr_req, sleep_req, port_read_req} = '0;
    {rst, ext_irq_pin, reg_addr, reg_wdata, port_pins, periph_ev} = {2'b11, 30'h0};
    rst_cause = mic_pkg::MIC_RST_POR;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset(mic_pkg::PWR_POR_VAL);
    t_periph();
    t_ext_pin();
    t_timer0();
    t_port();
    t_irq_out();
    t_sleep();
    @(posedge clk);
    rst_cause <= mic_pkg::MIC_RST_BOR;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset(mic_pkg::PWR_BOR_VAL);
    print_verdict();
  end
endmodule : tb
